// ===== dv/errq_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "errq_regs.vh"

module errq_monitor #(
    parameter DEPTH = `QUEUE_DEPTH
) (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        err_valid,
    input wire logic        err_ready,
    input wire logic        op_complete
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    // Helper terms: no event source active, read completing
    wire quiet   = !err_valid && !op_complete;
    wire rd_done = avs_read && !avs_waitrequest;

    // Two event reads with one idle cycle between and no event source active before the last read cycle
    sequence s_first_read;
        quiet && avs_read && avs_waitrequest && avs_address == `OFS_EVENT
        ##1 quiet && rd_done && avs_address == `OFS_EVENT;
    endsequence
    sequence s_second_read;
        (quiet && !avs_read) ##1 (quiet && avs_read && avs_address == `OFS_EVENT)
        ##1 (rd_done && avs_address == `OFS_EVENT);
    endsequence

    property p_one_wait;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    property p_empty_answer;
        rd_done && avs_address == `OFS_ERR_NEXT && !avs_readdata[`ERR_VALID_BIT]
            |-> avs_readdata == 32'h00000030;
    endproperty
    property p_code_form;
        rd_done && avs_address == `OFS_ERR_NEXT && avs_readdata[`ERR_VALID_BIT]
            |-> avs_readdata[31:17] == 15'h0000;
    endproperty
    property p_event_byte;
        rd_done && avs_address == `OFS_EVENT
            |-> avs_readdata[31:6] == 26'h0 && !avs_readdata[1];
    endproperty
    property p_event_clear;
        s_first_read ##1 s_second_read |-> avs_readdata == 32'h00000000;
    endproperty
    // A report may be held off only in the first, waited cycle of a bus request
    property p_ready_cause;
        !err_ready |-> (avs_read || avs_write) && avs_waitrequest;
    endproperty
    property p_unmapped;
        avs_read && avs_waitrequest && avs_address == 8'h40
            |-> !err_ready ##1 avs_readdata == 32'h00000000;
    endproperty
    property p_info_bound;
        rd_done && avs_address == `OFS_QUEUE_INFO |-> int'(avs_readdata[4:0]) <= DEPTH
            && avs_readdata[8] == (int'(avs_readdata[4:0]) == DEPTH);
    endproperty

    a_one_wait:     assert property (p_one_wait) else $error("waitrequest not one cycle");
    a_empty_answer: assert property (p_empty_answer) else $error("empty answer wrong");
    a_code_form:    assert property (p_code_form) else $error("code word malformed");
    a_event_byte:   assert property (p_event_byte) else $error("event read bad bits");
    a_event_clear:  assert property (p_event_clear) else $error("event not cleared");
    a_ready_cause:  assert property (p_ready_cause) else $error("err_ready low alone");
    a_unmapped:     assert property (p_unmapped) else $error("unmapped read wrong");
    a_info_bound:   assert property (p_info_bound) else $error("queue count bad");
endmodule

bind remote_error_queue_status errq_monitor #(.DEPTH(DEPTH)) u_mon (
    .clk             (clk),
    .reset           (reset),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .err_valid       (err_valid),
    .err_ready       (err_ready),
    .op_complete     (op_complete)
);

`default_nettype wire

// ===== dv/host_model.sv
`timescale 1ns/10ps
`default_nettype none

module host_model (
    input wire logic         clk,
    output logic [7:0]       avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic [31:0]      avs_writedata,
    output logic [3:0]       avs_byteenable,
    input wire logic [31:0]  avs_readdata,
    input wire logic         avs_waitrequest
);
    initial begin
        avs_address = 8'hFF;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
    end

    // Released address and data lines show the inverse so stale values never pass
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        avs_write <= 1'b1;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_address <= ~a;
        avs_writedata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        avs_read <= 1'b1;
        avs_address <= a;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
        avs_address <= ~a;
    endtask
endmodule

`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "errq_regs.vh"

module testbench;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        err_valid = 1'b0;
    logic [15:0] err_code = 16'h0000;
    logic        msg_avail = 1'b0;
    logic        op_complete = 1'b0;
    wire  [7:0]  avs_address;
    wire         avs_read, avs_write, avs_waitrequest, err_ready, irq;
    wire  [31:0] avs_writedata, avs_readdata;
    wire  [3:0]  avs_byteenable;
    int          fails = 0, n_checks = 0, cyc = 0, c;
    int          q[$];
    int          ev = 0;
    bit          marked = 0;
    logic [31:0] d;
    int          named[8] = '{-101, -112, -113, -222, -300, -321, -360, -400};

    always #10 clk = ~clk;

    host_model host (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    remote_error_queue_status #(.DEPTH(20), .AW(5)) DUT (.clk(clk), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .err_valid(err_valid), .err_code(err_code), .err_ready(err_ready),
        .msg_avail(msg_avail), .op_complete(op_complete), .irq(irq));

    // Class of a code as an event mask
    function automatic int cls(input int v);
        if (v <= -100 && v >= -199) return 32;
        if (v <= -200 && v >= -299) return 16;
        if (v <= -300 && v >= -399) return 8;
        if (v <= -400 && v >= -499) return 4;
        return 0;
    endfunction

    task automatic check_word(input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    task automatic check_bit(input logic e, input logic g);
        check_word({31'h0, e}, {31'h0, g});
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [31:0] e);
        host.rd(a, d);
        check_word(e, d);
    endtask

    // Full queue: first extra report marks overflow, later ones are dropped
    task automatic model_push(input int v);
        ev |= cls(v);
        if (q.size() < 20) q.push_back(v);
        else if (!marked) begin
            q[19] = -350;
            marked = 1;
            ev |= 8;
        end
    endtask

    task automatic push(input int v);
        @(posedge clk);
        err_valid <= 1'b1;
        err_code <= v[15:0];
        do @(posedge clk); while (err_ready !== 1'b1);
        err_valid <= 1'b0;
        model_push(v);
    endtask

    task automatic read_event();
        rd_check(`OFS_EVENT, ev);
        ev = 0;
    endtask

    task automatic pop_all();
        while (q.size() > 0) begin
            c = q.pop_front();
            marked = 0;
            rd_check(`OFS_ERR_NEXT, {15'h0, 1'b1, c[15:0]});
        end
        rd_check(`OFS_ERR_NEXT, 32'h00000030);
    endtask

    task automatic finish_test();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Hang guard, about twenty-five times the expected run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            fails++;
            finish_test();
        end
    end

    initial begin
        d = $urandom(62);
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        rd_check(`OFS_ERR_NEXT, 32'h00000030);
        read_event();
        $display("test startup done");
        foreach (named[i]) push(named[i]);
        read_event();
        read_event();
        pop_all();
        $display("test named codes done");
        // Random code in each class, then a completed operation
        for (int k = 1; k <= 4; k++) begin
            push(-(100 * k + $urandom_range(99, 0)));
            read_event();
        end
        @(posedge clk) op_complete <= 1'b1;
        @(posedge clk) op_complete <= 1'b0;
        ev |= 1;
        read_event();
        pop_all();
        $display("test classes done");
        for (int k = 0; k < 23; k++) push(-(100 + $urandom_range(399, 0)));
        rd_check(`OFS_QUEUE_INFO, 32'h00000314);
        read_event();
        rd_check(`OFS_IRQ_STATUS, 32'h00000003);
        pop_all();
        $display("test overflow done");
        host.wr(`OFS_EVENT_MASK, 32'h20, 4'h1);
        host.wr(`OFS_EVENT_MASK, 32'h00, 4'h0);
        rd_check(`OFS_EVENT_MASK, 32'h00000020);
        msg_avail <= 1'b1;
        push(-113);
        rd_check(`OFS_STATUS, 32'h00000030);
        host.wr(`OFS_SRQ_MASK, 32'h20, 4'h1);
        rd_check(`OFS_STATUS, 32'h00000070);
        host.wr(`OFS_CONTROL, 32'h1, 4'h1);
        q.delete();
        ev = 0;
        rd_check(`OFS_STATUS, 32'h00000010);
        read_event();
        pop_all();
        $display("test clear status done");
        host.wr(`OFS_IRQ_ENABLE, 32'h1, 4'h1);
        host.wr(`OFS_IRQ_CLEAR, 32'h3, 4'h1);
        @(posedge clk) check_bit(1'b0, irq);
        push(-222);
        @(posedge clk) check_bit(1'b1, irq);
        rd_check(`OFS_IRQ_STATUS, 32'h00000001);
        host.wr(`OFS_IRQ_CLEAR, 32'h1, 4'h1);
        @(posedge clk) check_bit(1'b0, irq);
        host.wr(`OFS_IRQ_ENABLE, 32'h0, 4'h1);
        push(-321);
        @(posedge clk) check_bit(1'b0, irq);
        rd_check(`OFS_IRQ_ENABLE, 32'h00000000);
        pop_all();
        $display("test interrupt done");
        rd_check(8'h40, 32'h00000000);
        model_push(-400);
        host.wr(8'h44, 32'h5, 4'h1);
        model_push(-113);
        host.wr(`OFS_EVENT_MASK, 32'h120, 4'h1);
        model_push(-222);
        rd_check(`OFS_EVENT_MASK, 32'h00000020);
        read_event();
        pop_all();
        $display("test unmapped done");
        finish_test();
    end
endmodule

`default_nettype wire

// ===== verilog/error_class.v
`timescale 1ns/10ps
`default_nettype none
`include "errq_regs.vh"

module error_class (
    input  wire [`CODE_W-1:0] code,
    output wire               cme,
    output wire               exe,
    output wire               dde,
    output wire               qye
);

    // All ranges sit in the negative half, so unsigned compares suffice
    // parser class range
    assign cme = (code >= `CME_LO) && (code <= `CME_HI);
    assign exe = (code >= `EXE_LO) && (code <= `EXE_HI);
    assign dde = (code >= `DDE_LO) && (code <= `DDE_HI);
    assign qye = (code >= `QYE_LO) && (code <= `QYE_HI);

endmodule
`default_nettype wire

// ===== verilog/error_fifo.v
`timescale 1ns/10ps
`default_nettype none
`include "errq_regs.vh"

module error_fifo #(
    parameter DEPTH = `QUEUE_DEPTH,
    parameter WIDTH = `CODE_W,
    parameter AW    = 5
) (
    input  wire             clk,
    input  wire             reset,
    input  wire             flush,
    input  wire             push,
    input  wire [WIDTH-1:0] push_data,
    input  wire             pop,
    output wire [WIDTH-1:0] pop_data,
    output wire [AW-1:0]    count,
    output wire             empty,
    output wire             full,
    output wire             marked,
    output wire             mark_pulse
);

    localparam [AW-1:0] DEPTH_C = DEPTH;
    localparam [AW-1:0] LAST_C  = DEPTH - 1;
    localparam [AW-1:0] ONE_C   = 1;

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    count_reg;
    reg             marked_reg;

    wire          do_pop  = pop && (count_reg != 0);
    wire          room    = (count_reg != DEPTH_C) || do_pop;
    wire          do_push = push && room;
    // once marked, further arrivals are dropped
    wire          do_mark = push && !room && !marked_reg;
    wire [AW-1:0] top_idx = (wr_ptr_reg == 0) ? LAST_C : wr_ptr_reg - ONE_C;

    assign pop_data   = mem[rd_ptr_reg];
    assign count      = count_reg;
    assign empty      = (count_reg == 0);
    assign full       = (count_reg == DEPTH_C);
    assign marked     = marked_reg;
    assign mark_pulse = do_mark;

    // Storage writes; no reset needed on the data words
    always @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr_reg] <= push_data;
        // newest slot becomes the overflow marker
        end else if (do_mark) begin
            mem[top_idx] <= `ERR_QUEUE_OVERFLOW;
        end
    end

    // Pointers and occupancy
    always @(posedge clk) begin
        // empty at start-up and on flush
        if (reset || flush) begin
            rd_ptr_reg <= {AW{1'b0}};
            wr_ptr_reg <= {AW{1'b0}};
            count_reg  <= {AW{1'b0}};
            marked_reg <= 1'b0;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= (wr_ptr_reg == LAST_C) ? {AW{1'b0}} : wr_ptr_reg + ONE_C;
            end
            if (do_pop) begin
                rd_ptr_reg <= (rd_ptr_reg == LAST_C) ? {AW{1'b0}} : rd_ptr_reg + ONE_C;
                marked_reg <= 1'b0;
            end else if (do_mark) begin
                marked_reg <= 1'b1;
            end
            if (do_push && !do_pop) begin
                count_reg <= count_reg + ONE_C;
            end else if (do_pop && !do_push) begin
                count_reg <= count_reg - ONE_C;
            end
        end
    end

endmodule
`default_nettype wire

// ===== verilog/errq_regs.vh
`ifndef ERRQ_REGS_VH
`define ERRQ_REGS_VH

// Register byte offsets, one 32-bit word each
`define OFS_ERR_NEXT   8'h00
`define OFS_EVENT      8'h04
`define OFS_EVENT_MASK 8'h08
`define OFS_STATUS     8'h0C
`define OFS_SRQ_MASK   8'h10
`define OFS_CONTROL    8'h14
`define OFS_QUEUE_INFO 8'h18
`define OFS_IRQ_STATUS 8'h1C
`define OFS_IRQ_CLEAR  8'h20
`define OFS_IRQ_ENABLE 8'h24

// Queue geometry
`define QUEUE_DEPTH    20
`define CODE_W         16

// Event register bit positions
`define EV_OPC         0
`define EV_QYE         2
`define EV_DDE         3
`define EV_EXE         4
`define EV_CME         5

// Status byte bit positions
`define ST_MAV         4
`define ST_ESB         5
`define ST_MSS         6

// Control register bits
`define CTL_CLEAR      0

// Interrupt bits
`define IRQ_W          2
`define IRQ_QUEUED     0
`define IRQ_OVERFLOW   1

// Queue information flag positions
`define INFO_FULL_BIT  8
`define INFO_MARK_BIT  9

// Read-back layout of the next-error register
`define ERR_VALID_BIT  16
`define ANSWER_NONE    8'h30

// Class range bounds, 16-bit two's complement
`define CME_LO         16'hFF39
`define CME_HI         16'hFF9C
`define EXE_LO         16'hFED5
`define EXE_HI         16'hFF38
`define DDE_LO         16'hFE71
`define DDE_HI         16'hFED4
`define QYE_LO         16'hFE0D
`define QYE_HI         16'hFE70

// Named error codes
`define ERR_INVALID_CHAR   16'hFF9B
`define ERR_MNEMONIC_LONG  16'hFF90
`define ERR_UNDEF_HEADER   16'hFF8F
`define ERR_OUT_OF_RANGE   16'hFF22
`define ERR_DEVICE         16'hFED4
`define ERR_OUT_OF_MEMORY  16'hFEBF
`define ERR_QUEUE_OVERFLOW 16'hFEA2
`define ERR_COMM_FAIL      16'hFE98
`define ERR_QUERY          16'hFE70

`endif

// ===== verilog/remote_error_queue_status.v
// Our own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
`include "errq_regs.vh"

module remote_error_queue_status #(
    parameter DEPTH = `QUEUE_DEPTH,
    parameter AW    = 5
) (
    input  wire                 clk,
    input  wire                 reset,
    input  wire [7:0]           avs_address,
    input  wire                 avs_read,
    input  wire                 avs_write,
    input  wire [31:0]          avs_writedata,
    input  wire [3:0]           avs_byteenable,
    output wire [31:0]          avs_readdata,
    output wire                 avs_waitrequest,
    input  wire                 err_valid,
    input  wire [`CODE_W-1:0]   err_code,
    output wire                 err_ready,
    input  wire                 msg_avail,
    input  wire                 op_complete,
    output wire                 irq
);

    // ------------------------------------------------------------------
    // Bus handshake: one wait cycle, then the answer
    // ------------------------------------------------------------------
    reg         ack_reg;
    reg  [31:0] rdata_reg;

    wire req      = avs_read || avs_write;
    wire first    = req && !ack_reg;
    wire rd_first = avs_read && first;
    wire wr_first = avs_write && first;
    wire lane0    = avs_byteenable[0];

    // Waitrequest drops the cycle after the request is seen
    assign avs_waitrequest = first;
    assign avs_readdata    = rdata_reg;

    always @(posedge clk) begin
        if (reset) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= first;
        end
    end

    // Address decode
    wire sel_next  = (avs_address == `OFS_ERR_NEXT);
    wire sel_event = (avs_address == `OFS_EVENT);
    wire sel_emask = (avs_address == `OFS_EVENT_MASK);
    wire sel_stat  = (avs_address == `OFS_STATUS);
    wire sel_smask = (avs_address == `OFS_SRQ_MASK);
    wire sel_ctl   = (avs_address == `OFS_CONTROL);
    wire sel_info  = (avs_address == `OFS_QUEUE_INFO);
    wire sel_ist   = (avs_address == `OFS_IRQ_STATUS);
    wire sel_iclr  = (avs_address == `OFS_IRQ_CLEAR);
    wire sel_ien   = (avs_address == `OFS_IRQ_ENABLE);

    wire rd_known = sel_next || sel_event || sel_emask || sel_stat || sel_smask
                 || sel_info || sel_ist || sel_ien;
    wire wr_known = sel_emask || sel_smask || sel_ctl || sel_iclr || sel_ien;

    // ------------------------------------------------------------------
    // Locally detected errors, fed into the same queue
    // ------------------------------------------------------------------
    wire mask_wr  = wr_first && lane0 && (sel_emask || sel_smask);
    wire too_wide = (avs_writedata[31:8] != 24'h000000);

    reg                 int_err;
    reg [`CODE_W-1:0]   int_code;

    always @* begin
        int_err  = 1'b0;
        int_code = `ERR_DEVICE;
        // unknown register written is an undefined header
        if (wr_first && !wr_known) begin
            int_err  = 1'b1;
            int_code = `ERR_UNDEF_HEADER;
        // reading nowhere is a query error
        end else if (rd_first && !rd_known) begin
            int_err  = 1'b1;
            int_code = `ERR_QUERY;
        // mask value above one byte is out of range
        end else if (mask_wr && too_wide) begin
            int_err  = 1'b1;
            int_code = `ERR_OUT_OF_RANGE;
        end
    end

    // Local errors win the slot; the outside source waits a cycle
    assign err_ready = !int_err;

    wire               push      = int_err || err_valid;
    wire [`CODE_W-1:0] push_code = int_err ? int_code : err_code;

    // ------------------------------------------------------------------
    // Clear-status and queue
    // ------------------------------------------------------------------
    // clear-status from the control register
    wire cls = wr_first && lane0 && sel_ctl && avs_writedata[`CTL_CLEAR];
    // a read of the next-error register pops
    wire pop = rd_first && sel_next;

    wire [`CODE_W-1:0] head_code;
    wire [AW-1:0]      q_count;
    wire               q_empty;
    wire               q_full;
    wire               q_marked;
    wire               q_mark;

    // flushed by clear-status, drained naturally by the last read
    error_fifo #(
        .DEPTH      (DEPTH),
        .WIDTH      (`CODE_W),
        .AW         (AW)
    ) u_fifo (
        .clk        (clk),
        .reset      (reset),
        .flush      (cls),
        .push       (push),
        .push_data  (push_code),
        .pop        (pop),
        .pop_data   (head_code),
        .count      (q_count),
        .empty      (q_empty),
        .full       (q_full),
        .marked     (q_marked),
        .mark_pulse (q_mark)
    );

    // ------------------------------------------------------------------
    // Error classes into the event register
    // ------------------------------------------------------------------
    wire c_cme;
    wire c_exe;
    wire c_dde;
    wire c_qye;

    // Class follows the code even when the queue drops it
    error_class u_class (
        .code (push_code),
        .cme  (c_cme),
        .exe  (c_exe),
        .dde  (c_dde),
        .qye  (c_qye)
    );

    reg  [7:0] event_reg;
    reg  [7:0] event_next;
    reg  [7:0] emask_reg;
    reg  [7:0] smask_reg;
    reg  [7:0] ev_set;

    wire ev_read = rd_first && sel_event;

    always @* begin
        ev_set = 8'h00;
        ev_set[`EV_CME] = push && c_cme;
        ev_set[`EV_EXE] = push && c_exe;
        // device error flag, overflow marker included
        ev_set[`EV_DDE] = (push && c_dde) || q_mark;
        ev_set[`EV_QYE] = push && c_qye;
        ev_set[`EV_OPC] = op_complete;
    end

    // New events beat the read or clear in the same cycle
    always @* begin
        event_next = event_reg;
        if (ev_read || cls) begin
            event_next = 8'h00;
        end
        event_next = event_next | ev_set;
    end

    always @(posedge clk) begin
        if (reset) begin
            event_reg <= 8'h00;
        end else begin
            event_reg <= event_next;
        end
    end

    // Mask registers take only in-range byte values
    always @(posedge clk) begin
        if (reset) begin
            emask_reg <= 8'h00;
            smask_reg <= 8'h00;
        end else if (mask_wr && !too_wide) begin
            if (sel_emask) begin
                emask_reg <= avs_writedata[7:0];
            end else begin
                smask_reg <= avs_writedata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Status byte, derived live so clearing events clears its ESB bit too
    // ------------------------------------------------------------------
    reg msg_meta_reg;
    reg msg_sync_reg;

    // Message flag may come from slower logic, so resync it
    always @(posedge clk) begin
        if (reset) begin
            msg_meta_reg <= 1'b0;
            msg_sync_reg <= 1'b0;
        end else begin
            msg_meta_reg <= msg_avail;
            msg_sync_reg <= msg_meta_reg;
        end
    end

    reg [7:0] status_byte;

    always @* begin
        status_byte = 8'h00;
        status_byte[`ST_MAV] = msg_sync_reg;
        status_byte[`ST_ESB] = |(event_reg & emask_reg);
        status_byte[`ST_MSS] = |(status_byte & smask_reg);
    end

    // ------------------------------------------------------------------
    // Interrupts: sticky status, write-one clear, enable
    // ------------------------------------------------------------------
    reg  [`IRQ_W-1:0] ist_reg;
    reg  [`IRQ_W-1:0] ien_reg;
    reg  [`IRQ_W-1:0] ist_set;

    wire iclr_wr = wr_first && lane0 && sel_iclr;
    wire ien_wr  = wr_first && lane0 && sel_ien;

    always @* begin
        ist_set = {`IRQ_W{1'b0}};
        ist_set[`IRQ_QUEUED]   = push && (!q_full || pop);
        ist_set[`IRQ_OVERFLOW] = q_mark;
    end

    // Set wins over clear on the same edge
    always @(posedge clk) begin
        if (reset) begin
            ist_reg <= {`IRQ_W{1'b0}};
            ien_reg <= {`IRQ_W{1'b0}};
        end else begin
            if (iclr_wr) begin
                ist_reg <= (ist_reg & ~avs_writedata[`IRQ_W-1:0]) | ist_set;
            end else begin
                ist_reg <= ist_reg | ist_set;
            end
            if (ien_wr) begin
                ien_reg <= avs_writedata[`IRQ_W-1:0];
            end
        end
    end

    assign irq = |(ist_reg & ien_reg);

    // ------------------------------------------------------------------
    // Read data, captured on the edge that takes the request
    // ------------------------------------------------------------------
    reg [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h00000000;
        if (sel_next) begin
            // empty queue answers the character zero
            if (q_empty) begin
                rd_mux[7:0] = `ANSWER_NONE;
            end else begin
                rd_mux[`CODE_W-1:0]    = head_code;
                rd_mux[`ERR_VALID_BIT] = 1'b1;
            end
        end else if (sel_event) begin
            // full eight bits before the clear
            rd_mux[7:0] = event_reg;
        end else if (sel_emask) begin
            rd_mux[7:0] = emask_reg;
        end else if (sel_stat) begin
            rd_mux[7:0] = status_byte;
        end else if (sel_smask) begin
            rd_mux[7:0] = smask_reg;
        end else if (sel_info) begin
            rd_mux[AW-1:0] = q_count;
            rd_mux[`INFO_FULL_BIT] = q_full;
            rd_mux[`INFO_MARK_BIT] = q_marked;
        end else if (sel_ist) begin
            rd_mux[`IRQ_W-1:0] = ist_reg;
        end else if (sel_ien) begin
            rd_mux[`IRQ_W-1:0] = ien_reg;
        end
    end

    // Holds the last answer until the next read; writes leave it alone
    always @(posedge clk) begin
        if (reset) begin
            rdata_reg <= 32'h00000000;
        end else if (rd_first) begin
            rdata_reg <= rd_mux;
        end
    end

endmodule
`default_nettype wire
